// ### dea_consts.vh
// Purpose: shared constants for the data nonvolatile array access block
// Assumes: 8-bit special function register bus, byte addresses as printed
// Notes:   definitions only
`ifndef DEA_CONSTS_VH
`define DEA_CONSTS_VH

// register addresses
`define DEA_ADR_BYTE_BUF     8'h9A
`define DEA_ADR_LOC_SEL      8'h9B
`define DEA_ADR_CONTROL      8'h9C
`define DEA_ADR_UNLOCK       8'h9D

// array geometry
`define DEA_DEPTH            128
`define DEA_LOC_W            7
`define DEA_LOC_MSB          6
`define DEA_LAST_LOC         7'h7F

// control register field positions
`define DEA_BIT_RD           0
`define DEA_BIT_WR           1
`define DEA_BIT_EN           2
`define DEA_BIT_ABORT        3

// reset and fixed values
`define DEA_BYTE_ZERO        8'h00
`define DEA_LOC_ZERO         7'h00
`define DEA_ERASED           8'hFF
`define DEA_UPPER_ZERO       4'h0

// unlock sequence keys and spacing in clocks
`define DEA_KEY_FIRST        8'h55
`define DEA_KEY_SECOND       8'hAA
`define DEA_GAP_KEYS         3'h2
`define DEA_GAP_TRIGGER      3'h1
`define DEA_GAP_ZERO         3'h0
`define DEA_GAP_ONE          3'h1

// self-timer widths
`define DEA_TMR_W            16
`define DEA_TMR_ZERO         16'h0000
`define DEA_TMR_ONE          16'h0001

`endif

// ### dea_ctrl.v
// Purpose: indirect access controller for a 128-byte data nonvolatile array
// Assumes: cpu register port and programmer port on clk_sys; rst synchronous
// Notes:   cpu write is erase then program, self-timed; unlock keys gate each cpu write
//
// Contract
// - 128 byte array, locations 0 to 7F
// - only low seven location bits select
// - byte buffer register; array reached indirectly
// - each cpu write erases then programs automatically
// - self-timer sets write length; wait done
// - triggers set-only; hardware clears on finish
// - cpu writes need program enable; enable resets cleared
// - abort flag set when warm reset cuts write
// - reset clears byte buffer and location
// - done flag set on write end; software clears
// - unlock port stores nothing, reads zero
// - control implements four low bits only
// - protection blocks programmer, not cpu
// - exact 55, AA, trigger sequence starts write
// - read result in buffer next cycle, held
// - write trigger blocked without enable; clearing harmless
`timescale 1ns/10ps
`include "dea_consts.vh"

module dea_ctrl #(
  parameter [`DEA_TMR_W-1:0] ERASE_CYCLES = 16'h03E8,
  parameter [`DEA_TMR_W-1:0] PROG_CYCLES  = 16'h03E8
) (
  input  wire                  clk_sys,
  input  wire                  rst,
  input  wire                  rst_power_up,
  input  wire [7:0]            sfr_addr,
  input  wire                  sfr_wr,
  input  wire [7:0]            sfr_wdata,
  input  wire                  sfr_rd,
  output reg  [7:0]            sfr_rdata,
  output wire                  program_done_flag,
  input  wire                  done_flag_clr,
  output wire                  write_busy,
  input  wire                  code_protect,
  input  wire                  prg_wr,
  input  wire                  prg_rd,
  input  wire [`DEA_LOC_W-1:0] prg_addr,
  input  wire [7:0]            prg_wdata,
  output reg  [7:0]            prg_rdata
);

  // sequencer states, one-hot
  localparam [2:0] U_IDLE = 3'b001;
  localparam [2:0] U_KEY1 = 3'b010;
  localparam [2:0] U_KEY2 = 3'b100;
  localparam [2:0] W_IDLE  = 3'b001;
  localparam [2:0] W_ERASE = 3'b010;
  localparam [2:0] W_PROG  = 3'b100;

  reg [7:0]            mem [0:`DEA_DEPTH-1];
  reg [7:0]            byte_buf_q;
  reg [`DEA_LOC_W-1:0] loc_q;
  reg                  rd_q;
  reg                  wr_q;
  reg                  en_q;
  reg                  abort_q;
  reg                  done_q;
  reg [2:0]            ust_q;
  reg [2:0]            gap_q;
  reg [2:0]            wst_q;
  reg [`DEA_TMR_W-1:0] tmr_q;
  reg [`DEA_LOC_W-1:0] wloc_q;
  reg [7:0]            wdat_q;

  wire wr_byte   = sfr_wr && (sfr_addr == `DEA_ADR_BYTE_BUF);
  wire wr_loc    = sfr_wr && (sfr_addr == `DEA_ADR_LOC_SEL);
  wire wr_ctl    = sfr_wr && (sfr_addr == `DEA_ADR_CONTROL);
  wire wr_unlock = sfr_wr && (sfr_addr == `DEA_ADR_UNLOCK);
  wire busy      = wr_q;

  // write start needs enable, armed keys at exact spacing, idle array
  wire unlocked  = (ust_q == U_KEY2) && (gap_q == `DEA_GAP_TRIGGER);
  wire start_wr  = wr_ctl && sfr_wdata[`DEA_BIT_WR] && en_q && unlocked && !busy;
  // read trigger ignored while a write is running
  wire start_rd  = wr_ctl && sfr_wdata[`DEA_BIT_RD] && !busy && !rd_q;
  wire wr_finish = (wst_q == W_PROG) && (tmr_q == `DEA_TMR_ONE);

  assign program_done_flag = done_q;
  assign write_busy        = busy;

  ////////////////////////////////////////////////////////////////////////////
  // unlock key sequencer; any stray write or wrong spacing drops it
  always @(posedge clk_sys) begin
    if (rst) begin
      ust_q <= U_IDLE;
      gap_q <= `DEA_GAP_ZERO;
    end else begin
      gap_q <= gap_q + `DEA_GAP_ONE;
      case (ust_q)
        U_IDLE: begin
          if (wr_unlock && sfr_wdata == `DEA_KEY_FIRST) begin
            ust_q <= U_KEY1;
            gap_q <= `DEA_GAP_ONE;
          end
        end
        U_KEY1: begin
          if (sfr_wr || gap_q == `DEA_GAP_KEYS) begin
            if (wr_unlock && sfr_wdata == `DEA_KEY_SECOND && gap_q == `DEA_GAP_KEYS) begin
              ust_q <= U_KEY2;
              gap_q <= `DEA_GAP_ONE;
            end else begin
              ust_q <= U_IDLE;
            end
          end
        end
        U_KEY2: begin
          // one chance only: the trigger write at the exact spacing
          if (sfr_wr || gap_q == `DEA_GAP_TRIGGER)
            ust_q <= U_IDLE;
        end
        default: ust_q <= U_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // self-timed erase then program; timer length is not software's to pick
  always @(posedge clk_sys) begin
    if (rst) begin
      wst_q  <= W_IDLE;
      tmr_q  <= `DEA_TMR_ZERO;
      wloc_q <= `DEA_LOC_ZERO;
      wdat_q <= `DEA_BYTE_ZERO;
    end else begin
      case (wst_q)
        W_IDLE: begin
          if (start_wr) begin
            wst_q  <= W_ERASE;
            tmr_q  <= ERASE_CYCLES;
            wloc_q <= loc_q;
            wdat_q <= byte_buf_q;
          end
        end
        W_ERASE: begin
          if (tmr_q == `DEA_TMR_ONE) begin
            wst_q <= W_PROG;
            tmr_q <= PROG_CYCLES;
          end else begin
            tmr_q <= tmr_q - `DEA_TMR_ONE;
          end
        end
        W_PROG: begin
          if (tmr_q == `DEA_TMR_ONE)
            wst_q <= W_IDLE;
          else
            tmr_q <= tmr_q - `DEA_TMR_ONE;
        end
        default: wst_q <= W_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // array port: cpu write cycle first, programmer only when unprotected
  always @(posedge clk_sys) begin
    if (!rst && wst_q == W_ERASE && tmr_q == `DEA_TMR_ONE)
      mem[wloc_q] <= `DEA_ERASED;
    else if (!rst && wr_finish)
      mem[wloc_q] <= wdat_q;
    else if (!rst && prg_wr && !code_protect && !busy)
      mem[prg_addr] <= prg_wdata;
  end

  // programmer read sees zeros under protection
  always @(posedge clk_sys) begin
    if (rst)
      prg_rdata <= `DEA_BYTE_ZERO;
    else if (prg_rd)
      prg_rdata <= code_protect ? `DEA_BYTE_ZERO : mem[prg_addr];
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte buffer and location; both come back cleared from any reset
  always @(posedge clk_sys) begin
    if (rst) begin
      byte_buf_q <= `DEA_BYTE_ZERO;
      loc_q      <= `DEA_LOC_ZERO;
    end else begin
      if (rd_q)
        byte_buf_q <= mem[loc_q];
      else if (wr_byte)
        byte_buf_q <= sfr_wdata;
      if (wr_loc)
        loc_q <= sfr_wdata[`DEA_LOC_MSB:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control bits; triggers only set by software, cleared by hardware
  always @(posedge clk_sys) begin
    if (rst) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      en_q <= 1'b0;
      // abort flag survives warm reset; power-up or a control write with bit 3 low clears it
      if (rst_power_up)
        abort_q <= 1'b0;
      else if (wr_q)
        abort_q <= 1'b1;
    end else begin
      if (start_rd)
        rd_q <= 1'b1;
      else if (rd_q)
        rd_q <= 1'b0;
      if (start_wr)
        wr_q <= 1'b1;
      else if (wr_finish)
        wr_q <= 1'b0;
      // clearing enable mid-write leaves the cycle alone
      if (wr_ctl)
        en_q <= sfr_wdata[`DEA_BIT_EN];
      if (wr_ctl)
        abort_q <= sfr_wdata[`DEA_BIT_ABORT];
    end
  end

  // completion flag, set beats a same-cycle clear
  always @(posedge clk_sys) begin
    if (rst)
      done_q <= 1'b0;
    else if (wr_finish)
      done_q <= 1'b1;
    else if (done_flag_clr)
      done_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered read-back; unmapped and unlock addresses return zero
  always @(posedge clk_sys) begin
    if (rst) begin
      sfr_rdata <= `DEA_BYTE_ZERO;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `DEA_ADR_BYTE_BUF: sfr_rdata <= byte_buf_q;
        `DEA_ADR_LOC_SEL:  sfr_rdata <= {1'b0, loc_q};
        `DEA_ADR_CONTROL:  sfr_rdata <= {`DEA_UPPER_ZERO, abort_q, en_q, wr_q, rd_q};
        `DEA_ADR_UNLOCK:   sfr_rdata <= `DEA_BYTE_ZERO;
        default:           sfr_rdata <= `DEA_BYTE_ZERO;
      endcase
    end
  end

endmodule // dea_ctrl

// ### dea_ctrl_sva.sv
// Purpose: port checker for dea_ctrl
// Assumes: one clock, rst synchronous active high
// Notes:   write length follows the timer parameters
`timescale 1ns/10ps
module dea_ctrl_sva #(
  parameter [15:0] ERASE_CYCLES = 16'h03E8,
  parameter [15:0] PROG_CYCLES  = 16'h03E8
) (
  input wire       clk_sys,
  input wire       rst,
  input wire [7:0] sfr_addr,
  input wire       sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire       sfr_rd,
  input wire [7:0] sfr_rdata,
  input wire       program_done_flag,
  input wire       done_flag_clr,
  input wire       write_busy,
  input wire       code_protect,
  input wire       prg_rd,
  input wire [7:0] prg_rdata
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  reg  [16:0] bcnt_q;
  wire [16:0] bcnt_d = write_busy ? bcnt_q + 17'h1 : 17'h0;
  // busy length counter, cleared by reset so a cut write never leaks
  always @(posedge clk_sys) bcnt_q <= rst ? 17'h0 : bcnt_d;
  ////////////////////////////////////////
  rst_clear_a: assert property (
    disable iff (1'b0) rst |=> !write_busy && !program_done_flag && sfr_rdata == 8'h00) else $error("reset left state");
  unlock_zero_a: assert property (sfr_rd && sfr_addr == 8'h9D |=> sfr_rdata == 8'h00)
    else $error("unlock port not zero");
  ctrl_upper_a: assert property (sfr_rd && sfr_addr == 8'h9C |=> sfr_rdata[7:4] == 4'h0)
    else $error("control upper bits set");
  loc_msb_a: assert property (sfr_rd && sfr_addr == 8'h9B |=> !sfr_rdata[7])
    else $error("location bit seven kept");
  done_on_end_a: assert property ($fell(write_busy) |-> program_done_flag)
    else $error("done flag missing at write end");
  done_hold_a: assert property (program_done_flag && !done_flag_clr |=> program_done_flag)
    else $error("done flag dropped by itself");
  start_seq_a: assert property ($rose(write_busy) |->
    $past(sfr_wr) && $past(sfr_addr) == 8'h9C && $past(sfr_wdata[1]) &&
    $past(sfr_wr, 2) && $past(sfr_addr, 2) == 8'h9D && $past(sfr_wdata, 2) == 8'hAA &&
    $past(sfr_wr, 4) && $past(sfr_addr, 4) == 8'h9D && $past(sfr_wdata, 4) == 8'h55)
    else $error("write started without unlock");
  write_len_a: assert property ($fell(write_busy) |-> bcnt_q == ERASE_CYCLES + PROG_CYCLES)
    else $error("write length wrong");
  prot_read_a: assert property (code_protect && prg_rd |=> prg_rdata == 8'h00)
    else $error("protected data leaked");
endmodule // dea_ctrl_sva
bind dea_ctrl dea_ctrl_sva #(.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES)) u_sva (.clk_sys(clk_sys),
  .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
  .sfr_rdata(sfr_rdata), .program_done_flag(program_done_flag), .done_flag_clr(done_flag_clr),
  .write_busy(write_busy), .code_protect(code_protect), .prg_rd(prg_rd), .prg_rdata(prg_rdata));

// ### dea_prog_model.sv
// Purpose: external programmer model, read and write side
// Assumes: same clock as the controller
// Notes:   address and data scrambled while idle, no stale value lingers
`timescale 1ns/10ps
module dea_prog_model (
  input  wire       clk_sys,
  input  wire       rd_go,
  input  wire       wr_go,
  input  wire [6:0] rd_loc,
  input  wire [7:0] wr_byte,
  output reg        prg_rd = 1'b0,
  output reg        prg_wr = 1'b0,
  output reg  [6:0] prg_addr = 7'h00,
  output reg  [7:0] prg_wdata = 8'h00
);
  // one strobe per request, address and data valid with it
  always @(posedge clk_sys) begin
    prg_rd <= rd_go;
    prg_wr <= wr_go;
    prg_addr <= (rd_go || wr_go) ? rd_loc : ~prg_addr;
    prg_wdata <= wr_go ? wr_byte : ~prg_wdata;
  end
endmodule // dea_prog_model

// ### dea_ctrl_test.sv
// Purpose: self-checking bench for dea_ctrl
// Assumes: short timers, three cycles each
// Notes:   read results queued, compared at the next falling edge
`timescale 1ns/10ps
module dea_ctrl_test;
  reg        clk_sys = 1'b0, rst = 1'b1, rst_power_up = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
  reg        done_flag_clr = 1'b0, code_protect = 1'b0, rd_go = 1'b0, wr_go = 1'b0, seen = 1'b0;
  reg  [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, wr_byte = 8'h00, d, r;
  reg  [6:0] rd_loc = 7'h00, a;
  wire [7:0] sfr_rdata, prg_rdata, prg_wdata;
  wire [6:0] prg_addr;
  wire       program_done_flag, write_busy, prg_rd, prg_wr;
  integer    err_count = 0, n_checks = 0, seed = 32'h6a61, i;
  reg  [7:0] exp_q[$];
  dea_ctrl #(.ERASE_CYCLES(16'h0003), .PROG_CYCLES(16'h0003)) uut (.clk_sys, .rst, .rst_power_up, .sfr_addr,
    .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata, .program_done_flag, .done_flag_clr, .write_busy, .code_protect,
    .prg_wr, .prg_rd, .prg_addr, .prg_wdata, .prg_rdata);
  dea_prog_model u_prog (.clk_sys, .rd_go, .wr_go, .rd_loc, .wr_byte, .prg_rd, .prg_wr, .prg_addr, .prg_wdata);
  initial forever #4 clk_sys = ~clk_sys;
  ////////////////////////////////////////
  task chk(input [7:0] sv, input [7:0] ev, input string what);
    begin
      n_checks = n_checks + 1;
      if (sv !== ev) begin
        err_count = err_count + 1;
        $display("[ERR] %0s exp %h seen %h", what, ev, sv);
      end
    end
  endtask
  task wr(input [7:0] ad, input [7:0] dt);
    begin
      @(posedge clk_sys);
      sfr_wr <= 1'b1;
      sfr_addr <= ad;
      sfr_wdata <= dt;
    end
  endtask
  task nop;
    @(posedge clk_sys) sfr_wr <= 1'b0;
  endtask
  task w(input [7:0] ad, input [7:0] dt);
    begin wr(ad, dt); nop; end
  endtask
  task rd(input [7:0] ad, input [7:0] ex);
    begin
      @(posedge clk_sys);
      sfr_rd <= 1'b1;
      sfr_addr <= ad;
      exp_q.push_back(ex);
      @(posedge clk_sys) sfr_rd <= 1'b0;
    end
  endtask
  // keys two apart, trigger right after the second key
  task unlock(input [7:0] trig);
    begin wr(8'h9D, 8'h55); nop; wr(8'h9D, 8'hAA); w(8'h9C, trig); @(negedge clk_sys); end
  endtask
  task do_rst(input pu);
    begin
      @(posedge clk_sys);
      rst <= 1'b1;
      rst_power_up <= pu;
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
    end
  endtask
  task prd(input p, input [7:0] ex);
    begin
      @(posedge clk_sys);
      rd_go <= 1'b1;
      rd_loc <= a;
      code_protect <= p;
      @(posedge clk_sys) rd_go <= 1'b0;
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk(prg_rdata, ex, "prg_rdata");
    end
  endtask
  // programmer write; lands on the second edge after the request
  task pwr(input p, input [7:0] dt);
    begin
      @(posedge clk_sys);
      wr_go <= 1'b1;
      rd_loc <= a;
      wr_byte <= dt;
      code_protect <= p;
      @(posedge clk_sys) wr_go <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // read data is registered, so compare once the edge after the strobe has landed
  always @(posedge clk_sys) seen <= sfr_rd;
  always @(negedge clk_sys) if (seen) chk(sfr_rdata, exp_q.pop_front(), "sfr_rdata");
  initial begin repeat (3000) @(posedge clk_sys); err_count = err_count + 1; summarize; end
  initial begin
    do_rst(1'b1);
    for (r = 8'h9A; r < 8'h9F; r = r + 8'h01) rd(r, 8'h00);
    $display("reset values done");
    d = $random(seed);
    a = $random(seed);
    w(8'h9B, {1'b1, a});
    w(8'h9A, d);
    w(8'h9C, 8'h04);
    unlock(8'h06);
    chk({7'h00, write_busy}, 8'h01, "busy");
    // drop enable and try a read trigger mid-write: both must leave the cycle alone
    w(8'h9C, 8'h01);
    rd(8'h9C, 8'h02);
    for (i = 0; i < 40 && write_busy !== 1'b0; i = i + 1) @(negedge clk_sys);
    chk({7'h00, program_done_flag}, 8'h01, "done");
    @(posedge clk_sys) done_flag_clr <= 1'b1;
    @(posedge clk_sys) done_flag_clr <= 1'b0;
    @(negedge clk_sys) chk({7'h00, program_done_flag}, 8'h00, "done clr");
    rd(8'h9B, {1'b0, a});
    rd(8'h9C, 8'h00);
    w(8'h9A, ~d);
    w(8'h9C, 8'h05);
    rd(8'h9A, d);
    prd(1'b1, 8'h00);
    prd(1'b0, d);
    pwr(1'b1, ~d);
    prd(1'b0, d);
    pwr(1'b0, ~d);
    prd(1'b0, ~d);
    $display("write and read done");
    w(8'h9D, 8'h55);
    w(8'h9D, 8'hAA);
    w(8'h9C, 8'h06);
    @(negedge clk_sys);
    chk({7'h00, write_busy}, 8'h00, "late trigger");
    w(8'h9C, 8'h00);
    unlock(8'h02);
    chk({7'h00, write_busy}, 8'h00, "no enable");
    $display("refused writes done");
    w(8'h9B, {1'b0, a});
    w(8'h9C, 8'h04);
    unlock(8'h06);
    do_rst(1'b0);
    rd(8'h9C, 8'h08);
    rd(8'h9A, 8'h00);
    rd(8'h9B, 8'h00);
    do_rst(1'b1);
    rd(8'h9C, 8'h00);
    @(posedge clk_sys);
    @(negedge clk_sys);
    $display("reset abort done");
    summarize;
  end
endmodule // dea_ctrl_test
